// ---- rtl/rgbled_ctrl.v ----
// Purpose: I2C write-only command target driving three PWM LED channels with ramps
// Assumes: scl/sda are synchronous samples; sda is open drain (oe high pulls low)
// Notes: current step output is a code 0..30; the analog side maps it to current
//
// Overview of operation
// - One frame: address byte then one command
// - Answer only address 0x38, write only
// - Command bits 7:5 select, 4:0 payload
// - Selector 0 shuts all outputs off
// - Selector 1 stores shared current step
// - Current step applied at once on ack
// - Selectors 2,3,4 load red, green, blue duty
// - Selectors 5,6 load rise and fall targets
// - Targets are step codes, not currents
// - Selector 7 loads step time, starts ramp if nonzero and target differs from current
// - Ramp time is step time times steps
// - Ramp walks current one step at a time
// - Step code profile gives exponential current
// - Current kept within bounds, no bad state
// - Ramp starts at command acknowledge
// - Registers load separately; last rise or fall write sets the target
// - Thirty-two duty levels per channel
// - Step 31 acts as step 30
// - Step count is absolute difference
// - Duty zero off, all ones fully on
// - PWM near 2.1 kHz, 31 slots
`include "rgbled_regs.vh"

module rgbled_ctrl #(
  parameter integer UNIT_TICKS = `RGBLED_UNIT_TICKS,
  parameter integer TICK_CYC = `RGBLED_TICK_CYC,
  parameter integer PWM_TICKS = `RGBLED_PWM_TICKS
) (
  // Clock and reset
  input wire ref_clk_in,
  input wire rst_in,
  // I2C pins
  input wire scl_in,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe_out,
  // LED drive
  output reg red_on_out,
  output reg green_on_out,
  output reg blue_on_out,
  output reg [4:0] led_current_step_out,
  output reg ramp_busy_out
);

  ////////////////////////////////////////////////////////////////
  // I2C receive
  localparam ST_IDLE = 3'd0;
  localparam ST_ADDR = 3'd1;
  localparam ST_AACK = 3'd2;
  localparam ST_DATA = 3'd3;
  localparam ST_DACK = 3'd4;
  localparam ST_DONE = 3'd5;

  reg scl_q;
  reg sda_q;
  reg [2:0] st_q;
  reg [3:0] bit_q;
  reg [7:0] sh_q;
  reg cmd_q;
  wire scl_rise = scl_in & ~scl_q;
  wire scl_fall = ~scl_in & scl_q;
  wire start_c = scl_in & scl_q & sda_q & ~sda_in;
  wire stop_c = scl_in & scl_q & ~sda_q & sda_in;

  always @(posedge ref_clk_in) begin
    scl_q <= scl_in;
    sda_q <= sda_in;
    cmd_q <= 1'b0;
    if (rst_in) begin
      st_q <= ST_IDLE;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      sda_oe_out <= 1'b0;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else if (start_c) begin
      st_q <= ST_ADDR;
      bit_q <= 4'h0;
      sda_oe_out <= 1'b0;
    end else if (stop_c) begin
      st_q <= ST_IDLE;
      sda_oe_out <= 1'b0;
    end else begin
      case (st_q)
        ST_ADDR, ST_DATA: begin
          if (scl_rise) begin
            sh_q <= {sh_q[6:0], sda_in};
            bit_q <= bit_q + 4'h1;
          end
          if (scl_fall && bit_q == 4'h8) begin
            bit_q <= 4'h0;
            if (st_q == ST_DATA || sh_q == {`RGBLED_ADDR, 1'b0}) begin
              sda_oe_out <= 1'b1;
              st_q <= (st_q == ST_ADDR) ? ST_AACK : ST_DACK;
            end else begin
              st_q <= ST_IDLE;
            end
          end
        end
        ST_AACK, ST_DACK: begin
          if (scl_fall) begin
            sda_oe_out <= 1'b0;
            cmd_q <= (st_q == ST_DACK);
            st_q <= (st_q == ST_AACK) ? ST_DATA : ST_DONE;
          end
        end
        ST_DONE: st_q <= ST_DONE;
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // Command registers
  reg [4:0] red_q;
  reg [4:0] green_q;
  reg [4:0] blue_q;
  reg [4:0] rise_q;
  reg [4:0] fall_q;
  reg [4:0] time_q;
  reg [4:0] cur_q;
  reg [4:0] end_q;
  reg run_q;
  reg [23:0] dwell_q;
  reg [23:0] dwell_cnt_q;
  reg [7:0] tick_q;
  wire [2:0] sel = sh_q[`RGBLED_SEL_MSB:`RGBLED_SEL_LSB];
  wire [4:0] pay = sh_q[`RGBLED_PAY_MSB:0];
  wire tick = (tick_q == 8'h00);

  function [4:0] clamp_step;
    input [4:0] s;
    begin
      clamp_step = (s > `RGBLED_STEP_MAX) ? `RGBLED_STEP_MAX : s;
    end
  endfunction

  always @(posedge ref_clk_in) begin
    if (rst_in || tick)
      tick_q <= TICK_CYC[7:0] - 8'h01;
    else
      tick_q <= tick_q - 8'h01;
  end

  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      red_q <= `RGBLED_RESET_VAL;
      green_q <= `RGBLED_RESET_VAL;
      blue_q <= `RGBLED_RESET_VAL;
      rise_q <= `RGBLED_RESET_VAL;
      fall_q <= `RGBLED_RESET_VAL;
      time_q <= `RGBLED_RESET_VAL;
      cur_q <= `RGBLED_RESET_VAL;
      end_q <= `RGBLED_RESET_VAL;
      run_q <= 1'b0;
      dwell_q <= 24'h000000;
      dwell_cnt_q <= 24'h000000;
    end else if (cmd_q) begin
      case (sel)
        `RGBLED_SEL_SHDN: begin
          cur_q <= 5'h00;
          run_q <= 1'b0;
        end
        `RGBLED_SEL_STEP: begin
          cur_q <= clamp_step(pay);
          run_q <= 1'b0;
        end
        `RGBLED_SEL_RED: red_q <= pay;
        `RGBLED_SEL_GREEN: green_q <= pay;
        `RGBLED_SEL_BLUE: blue_q <= pay;
        `RGBLED_SEL_RISE: begin
          rise_q <= clamp_step(pay);
          end_q <= clamp_step(pay);
        end
        `RGBLED_SEL_FALL: begin
          fall_q <= clamp_step(pay);
          end_q <= clamp_step(pay);
        end
        default: begin
          time_q <= pay;
          dwell_q <= pay * UNIT_TICKS[18:0];
          dwell_cnt_q <= 24'h000000;
          run_q <= (pay != 5'h00) && (end_q != cur_q);
        end
      endcase
    end else if (run_q && tick) begin
      if (dwell_cnt_q + 24'h000001 >= dwell_q) begin
        dwell_cnt_q <= 24'h000000;
        if (end_q > cur_q)
          cur_q <= cur_q + 5'h01;
        else if (end_q < cur_q)
          cur_q <= cur_q - 5'h01;
        if (end_q == cur_q + 5'h01 || cur_q == end_q + 5'h01 || end_q == cur_q)
          run_q <= 1'b0;
      end else begin
        dwell_cnt_q <= dwell_cnt_q + 24'h000001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // PWM, 31 slots per period
  reg [4:0] slot_q;
  reg [7:0] pdiv_q;
  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      slot_q <= 5'h00;
      pdiv_q <= 8'h00;
    end else if (tick) begin
      if (pdiv_q >= PWM_TICKS[7:0] - 8'h01) begin
        pdiv_q <= 8'h00;
        slot_q <= (slot_q >= 5'h1e) ? 5'h00 : slot_q + 5'h01;
      end else begin
        pdiv_q <= pdiv_q + 8'h01;
      end
    end
  end

  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      red_on_out <= 1'b0;
      green_on_out <= 1'b0;
      blue_on_out <= 1'b0;
      led_current_step_out <= 5'h00;
      ramp_busy_out <= 1'b0;
      sda_out <= 1'b0;
    end else begin
      red_on_out <= (red_q > slot_q) && (cur_q != 5'h00);
      green_on_out <= (green_q > slot_q) && (cur_q != 5'h00);
      blue_on_out <= (blue_q > slot_q) && (cur_q != 5'h00);
      led_current_step_out <= cur_q;
      ramp_busy_out <= run_q;
      sda_out <= 1'b0;
    end
  end

endmodule

// ---- rtl/rgbled_regs.vh ----
// Purpose: constants for the RGB LED dimming controller
// Assumes: included by rtl/rgbled_ctrl.v
// Notes: definitions only
`ifndef RGBLED_REGS_VH
`define RGBLED_REGS_VH
`define RGBLED_ADDR 7'h38
`define RGBLED_SEL_SHDN 3'h0
`define RGBLED_SEL_STEP 3'h1
`define RGBLED_SEL_RED 3'h2
`define RGBLED_SEL_GREEN 3'h3
`define RGBLED_SEL_BLUE 3'h4
`define RGBLED_SEL_RISE 3'h5
`define RGBLED_SEL_FALL 3'h6
`define RGBLED_SEL_GO 3'h7
`define RGBLED_SEL_MSB 7
`define RGBLED_SEL_LSB 5
`define RGBLED_PAY_MSB 4
`define RGBLED_RESET_VAL 5'h00
`define RGBLED_STEP_MAX 5'h1e
`define RGBLED_CLK_HZ 100000000
`define RGBLED_TICK_HZ 1000000
`define RGBLED_TICK_CYC (`RGBLED_CLK_HZ / `RGBLED_TICK_HZ)
`define RGBLED_PWM_HZ 2100
`define RGBLED_PWM_TICKS (`RGBLED_TICK_HZ / (`RGBLED_PWM_HZ * 31))
`define RGBLED_UNIT_MS 8
`define RGBLED_UNIT_TICKS (`RGBLED_UNIT_MS * 1000)
`endif

// ---- verification/rgbled_ctrl_asserts.sv ----
// Purpose: port assertions for rgbled_ctrl
// Assumes: short sim counts, scl high 8 clocks and low 10 clocks per bit on the bus
// Notes: bound at the foot of this file
module rgbled_ctrl_asserts (
  input wire ref_clk_in,
  input wire rst_in,
  input wire scl_in,
  input wire sda_in,
  input wire sda_out,
  input wire sda_oe_out,
  input wire red_on_out,
  input wire green_on_out,
  input wire blue_on_out,
  input wire [4:0] led_current_step_out,
  input wire ramp_busy_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  sequence s_ack_start;
    $rose(sda_oe_out);
  endsequence
  chk_sda_pull_only: assert property (!sda_out)
    else $error("sda driven high");
  chk_step_in_bounds: assert property (led_current_step_out <= 5'h1e)
    else $error("step above 30");
  chk_dark_at_zero: assert property (led_current_step_out == 5'h00 |-> !(red_on_out | green_on_out | blue_on_out))
    else $error("led on at step 0");
  chk_ramp_single_step: assert property (ramp_busy_out && $past(ramp_busy_out) |->
    (led_current_step_out - $past(led_current_step_out)) inside {5'h00, 5'h01, 5'h1f})
    else $error("ramp jumped");
  chk_ack_after_fall: assert property (s_ack_start |-> !scl_in && !$past(scl_in))
    else $error("ack not in low clock");
  chk_ack_stable_high: assert property (sda_oe_out && scl_in |=> sda_oe_out || !scl_in)
    else $error("ack dropped in high clock");
  chk_ack_window: assert property (s_ack_start |-> sda_oe_out[*8] ##[1:32] !sda_oe_out)
    else $error("ack length wrong");
  chk_reset_clear: assert property ($fell(rst_in) |-> led_current_step_out == 5'h00 && !ramp_busy_out)
    else $error("not clear after reset");
endmodule
bind rgbled_ctrl rgbled_ctrl_asserts rgbled_ctrl_asserts_inst (.*);

// ---- verification/rgbled_i2c_host.sv ----
// Purpose: bus controller model sending write frames
// Assumes: bench resolves open-drain sda with a pull-up
// Notes: scl high fixed at 8 clocks, low at 10 clocks per bit
module rgbled_i2c_host (
  input wire logic clk_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  // Last pass releases sda for the ack bit
  task automatic put(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= -1; i--) begin
      wt(2);
      sda_out <= (i < 0) ? 1'b1 : b[i];
      wt(8);
      scl_out <= 1'b1;
      wt(8);
      ack = !sda_in;
      scl_out <= 1'b0;
    end
  endtask
  task automatic frame(input logic [7:0] adr, input logic [7:0] cmd, output logic a1, output logic a2);
    wt(8);
    sda_out <= 1'b0;
    wt(8);
    scl_out <= 1'b0;
    put(adr, a1);
    put(cmd, a2);
    wt(2);
    sda_out <= 1'b0;
    wt(8);
    scl_out <= 1'b1;
    wt(8);
    sda_out <= 1'b1;
  endtask
endmodule

// ---- verification/test_rgbled_ctrl.sv ----
// Purpose: self-checking bench for rgbled_ctrl
// Assumes: unit counts shortened; one PWM period is 62 clocks
// Notes: PWM measured as on-clocks over one period
module test_rgbled_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [7:0] cmd; logic [4:0] st, r, g, b;} rgbled_row_t;
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic scl, hsda, sda_out, sda_oe_out, red, green, blue, busy, a1, a2;
  logic [4:0] step;
  wire sda = hsda & ~sda_oe_out;
  int error_cnt = 0;
  int check_count = 0;
  int cyc = 0;
  int busy_cyc = 0;
  rgbled_row_t rows [7] = '{'{8'h25, 5'h05, 5'h00, 5'h00, 5'h00}, '{8'h5f, 5'h05, 5'h1f, 5'h00, 5'h00},
    '{8'h6a, 5'h05, 5'h1f, 5'h0a, 5'h00}, '{8'h81, 5'h05, 5'h1f, 5'h0a, 5'h01},
    '{8'h3f, 5'h1e, 5'h1f, 5'h0a, 5'h01}, '{8'h00, 5'h00, 5'h00, 5'h00, 5'h00},
    '{8'h23, 5'h03, 5'h1f, 5'h0a, 5'h01}};
  rgbled_ctrl #(.UNIT_TICKS(4), .TICK_CYC(2), .PWM_TICKS(1)) rgbled_ctrl_inst (.ref_clk_in(ref_clk_in),
    .rst_in(rst_in), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
    .red_on_out(red), .green_on_out(green), .blue_on_out(blue), .led_current_step_out(step),
    .ramp_busy_out(busy));
  rgbled_i2c_host rgbled_i2c_host_inst (.clk_in(ref_clk_in), .sda_in(sda), .scl_out(scl), .sda_out(hsda));
  always #5 ref_clk_in = ~ref_clk_in;
  always @(posedge ref_clk_in) begin
    cyc <= cyc + 1;
    busy_cyc <= busy_cyc + int'(busy);
    if (cyc == 30000) begin
      error_cnt++;
      report_and_stop;
    end
  end
  task automatic report_and_stop;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [20:0] seen, input logic [20:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic send(input logic [7:0] cmd);
    rgbled_i2c_host_inst.frame(8'h70, cmd, a1, a2);
    chk("addr ack", 21'(a1), 21'h1);
    chk("cmd ack", 21'(a2), 21'h1);
  endtask
  task automatic meas(output logic [20:0] on);
    on = '0;
    repeat (62) @(posedge ref_clk_in);
    repeat (62) begin
      @(posedge ref_clk_in);
      on += (21'(red) << 14) + (21'(green) << 7) + 21'(blue);
    end
  endtask
  // Short dwell lets the ramp finish within the 700-clock wait
  task automatic ramp(input logic [7:0] tgt, input logic [7:0] go, input logic [4:0] fin, input int n);
    int dw;
    int b0;
    int bc;
    dw = int'(go[4:0]) * 8;
    // Target goes out before the start command
    send(tgt);
    // Busy is low here, so the running count is a clean base
    b0 = busy_cyc;
    send(go);
    repeat (700) @(posedge ref_clk_in);
    bc = busy_cyc - b0;
    chk("ramp end", 21'(step), 21'(fin));
    chk("ramp time", 21'(bc >= n * dw - dw && bc <= n * dw + dw), 21'h1);
  endtask
  initial begin
    logic [20:0] on;
    repeat (5) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    foreach (rows[i]) begin
      send(rows[i].cmd);
      meas(on);
      chk("step", 21'(step), 21'(rows[i].st));
      chk("pwm", on, {1'b0, rows[i].r, 2'b0, rows[i].g, 2'b0, rows[i].b, 1'b0});
    end
    for (int k = 1; k < 3; k++) begin
      rgbled_i2c_host_inst.frame(8'h70 | 8'(k), 8'h3e, a1, a2);
      chk("foreign ack", 21'(a1), 21'h0);
      chk("foreign step", 21'(step), 21'h03);
    end
    ramp(8'haf, 8'he1, 5'h0f, 12);
    ramp(8'hc1, 8'he4, 5'h01, 14);
    ramp(8'hbe, 8'he0, 5'h01, 0);
    rst_in <= 1'b1;
    repeat (5) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    meas(on);
    chk("reset pwm", on, 21'h0);
    chk("reset step", 21'(step), 21'h0);
    chk("reset busy", 21'(busy), 21'h0);
    report_and_stop;
  end
endmodule
